//--- core/sdrcfg_pkg.sv
// package for the sdram configuration and refresh block
// assumes a single pclk domain and an apb register port with 32-bit data
package sdrcfg_pkg;

    // register byte offsets
    localparam logic [11:0] SDRCFG_OFS_STATE_CMD = 12'h004;
    localparam logic [11:0] SDRCFG_OFS_DIRECT    = 12'h008;
    localparam logic [11:0] SDRCFG_OFS_GEOMETRY  = 12'h00c;
    localparam logic [11:0] SDRCFG_OFS_REFRESH   = 12'h010;
    localparam logic [11:0] SDRCFG_OFS_STATUS    = 12'h000;

    // reset values
    localparam logic [31:0] SDRCFG_GEOM_RESET    = 32'h0001_0020;
    localparam logic [14:0] SDRCFG_REFRESH_RESET = 15'h0a60;

    // geometry field positions
    localparam int SDRCFG_F_SELFREF    = 31;
    localparam int SDRCFG_F_FPT_HI     = 30;
    localparam int SDRCFG_F_FPT_LO     = 24;
    localparam int SDRCFG_F_FP_ON      = 23;
    localparam int SDRCFG_F_CHIPS_HI   = 22;
    localparam int SDRCFG_F_CHIPS_LO   = 21;
    localparam int SDRCFG_F_QOS_HI     = 20;
    localparam int SDRCFG_F_QOS_LO     = 18;
    localparam int SDRCFG_F_BURST_HI   = 17;
    localparam int SDRCFG_F_BURST_LO   = 15;
    localparam int SDRCFG_F_CLKSTOP    = 14;
    localparam int SDRCFG_F_AUTOPD     = 13;
    localparam int SDRCFG_F_PDCNT_HI   = 12;
    localparam int SDRCFG_F_PDCNT_LO   = 7;
    localparam int SDRCFG_F_APSEL      = 6;
    localparam int SDRCFG_F_ROW_HI     = 5;
    localparam int SDRCFG_F_ROW_LO     = 3;
    localparam int SDRCFG_F_COL_HI     = 2;
    localparam int SDRCFG_F_COL_LO     = 0;

    // field code limits and bases
    localparam logic [2:0] SDRCFG_BURST_MAX = 3'h4;
    localparam logic [2:0] SDRCFG_QOS_MAX   = 3'h4;
    localparam logic [2:0] SDRCFG_ROW_MAX   = 3'h5;
    localparam logic [2:0] SDRCFG_COL_MAX   = 3'h4;
    localparam logic [4:0] SDRCFG_ROW_BASE  = 5'h0b;
    localparam logic [4:0] SDRCFG_COL_BASE  = 5'h08;
    localparam logic [3:0] SDRCFG_AP_LINE_LO = 4'h8;
    localparam logic [3:0] SDRCFG_AP_LINE_HI = 4'ha;

    // controller state commands
    localparam logic [2:0] SDRCFG_CMD_PAUSE  = 3'h3;
    localparam logic [2:0] SDRCFG_CMD_CONFIG = 3'h4;
    localparam logic [2:0] SDRCFG_CMD_ACTIVE = 3'h7;
    localparam logic [2:0] SDRCFG_CMD_SLEEP  = 3'h2;
    localparam logic [2:0] SDRCFG_CMD_WAKE   = 3'h1;

    // direct command codes and field positions
    localparam logic [1:0] SDRCFG_DCMD_MODEREG = 2'h2;
    localparam int SDRCFG_F_DCMD_HI  = 19;
    localparam int SDRCFG_F_DCMD_LO  = 18;
    localparam int SDRCFG_F_DCHIP_HI = 21;
    localparam int SDRCFG_F_DCHIP_LO = 20;
    localparam int SDRCFG_F_DBANK_HI = 17;
    localparam int SDRCFG_F_DBANK_LO = 16;
    localparam int SDRCFG_F_DADDR_HI = 13;

    // state names
    typedef enum logic [1:0] {
        SDRCFG_ST_CONFIG,
        SDRCFG_ST_ACTIVE,
        SDRCFG_ST_PAUSED,
        SDRCFG_ST_LOWPWR
    } sdrcfg_state_e;

    // status encodings
    localparam logic [1:0] SDRCFG_STAT_CONFIG = 2'h0;
    localparam logic [1:0] SDRCFG_STAT_ACTIVE = 2'h1;
    localparam logic [1:0] SDRCFG_STAT_PAUSED = 2'h2;
    localparam logic [1:0] SDRCFG_STAT_LOWPWR = 2'h3;
    localparam int SDRCFG_F_STAT_CHIPS_LO = 2;

endpackage : sdrcfg_pkg

//--- core/sdrcfg_counter.sv
// down counter that pulses when a loaded interval has elapsed
// assumes load and count enable come from logic on the same clock
`timescale 1ns/1ps
module sdrcfg_counter
    import sdrcfg_pkg::*;
#(
    parameter int W = 15
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         restart,
    input  wire logic         run,
    input  wire logic [W-1:0] period,
    output logic              expired,
    output logic [W-1:0]      count
);

    logic [W-1:0] cnt_q;
    logic         exp_q;
    // last count of an interval: period n pulses every n cycles, zero every cycle
    wire          at_end = (cnt_q <= W'(1));

    // reload on restart, on expiry or while not running, else count down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            exp_q <= 1'b0;
            if (restart || !run) begin
                cnt_q <= period;
            end else if (at_end) begin
                cnt_q <= period;
                exp_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign expired = exp_q;
    assign count   = cnt_q;

endmodule : sdrcfg_counter

//--- core/sdrcfg_top.sv
// sdram configuration, refresh and low-power control with an apb register port
// assumes pclk is also the memory clock and fifo_empty comes from the same clock
//
// Summary of operation
// - geometry and refresh registers are accessed only in config or low-power state
// - auto power-down drops cke after the command fifo stays empty long enough
// - a six-bit idle count sets the cycles before automatic power-down
// - clock-stop enable gates the memory clock whenever no access runs
// - three-bit burst code 0..4 means bursts of 1, 2, 4, 8, 16
// - qos code 0..4 picks read id bits [3:0] up to [7:4]
// - auto-precharge flag goes on line 10, or line 8 when selected
// - row code 0..5 means 11 to 16 row address bits
// - column code 0..4 means 8 to 12 column address bits
// - commands go to one to four chips, never beyond the fitted count, save direct mode register accesses
// - force-precharge enable and seven-bit timeout govern closing open banks
// - auto self-refresh enable resets to zero
// - refresh fires every programmed fifteen-bit interval in active or paused state, reset 0xa60
// - state command codes 3 pause, 4 configure, 7 active
// - direct command code 2 issues a mode register access
`timescale 1ns/1ps
module sdrcfg_top
    import sdrcfg_pkg::*;
#(
    parameter logic [1:0] FITTED_CHIPS = 2'h3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fifo_empty,
    input  wire logic        access_busy,
    input  wire logic [7:0]  read_id,
    output logic             refresh_req,
    output logic             cke,
    output logic             mem_clk_en,
    output logic             selfref_allow,
    output logic             forced_precharge_on,
    output logic [6:0]       forced_precharge_timeout,
    output logic [3:0]       qos_index,
    output logic [4:0]       burst_beats,
    output logic [4:0]       row_width,
    output logic [4:0]       col_width,
    output logic [3:0]       autoprecharge_line,
    output logic [3:0]       chip_enables,
    output logic             modereg_pulse,
    output logic [1:0]       modereg_chip,
    output logic [1:0]       modereg_bank,
    output logic [13:0]      modereg_addr
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // chip code to thermometer enable mask, code n enables chips 0 to n
    function automatic logic [3:0] chip_mask(input logic [1:0] code);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (2'(i) <= code);
        end
        return m;
    endfunction : chip_mask

    ////////////////////////////////////////////////////////////////////////
    // state and registers

    sdrcfg_state_e state_q;
    sdrcfg_state_e state_d;
    logic [31:0]   geom_q;
    logic [14:0]   refr_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;

    // apb decode
    wire acc_phase = psel && penable && !pready_q;
    wire wr_phase  = acc_phase && pwrite;
    wire hit_geom  = (paddr == SDRCFG_OFS_GEOMETRY);
    wire hit_refr  = (paddr == SDRCFG_OFS_REFRESH);
    wire hit_cmd   = (paddr == SDRCFG_OFS_STATE_CMD);
    wire hit_dir   = (paddr == SDRCFG_OFS_DIRECT);
    wire hit_stat  = (paddr == SDRCFG_OFS_STATUS);
    wire cfg_open  = (state_q == SDRCFG_ST_CONFIG) || (state_q == SDRCFG_ST_LOWPWR);
    wire locked    = (hit_geom || hit_refr || hit_dir) && !cfg_open;
    wire unmapped  = !(hit_geom || hit_refr || hit_cmd || hit_dir || hit_stat);
    wire geom_we   = wr_phase && hit_geom && cfg_open;
    wire refr_we   = wr_phase && hit_refr && cfg_open;
    wire cmd_we    = wr_phase && hit_cmd;
    wire dir_we    = wr_phase && hit_dir && cfg_open;

    // fields out of the geometry register
    wire [2:0] burst_code = geom_q[SDRCFG_F_BURST_HI:SDRCFG_F_BURST_LO];
    wire [2:0] qos_code   = geom_q[SDRCFG_F_QOS_HI:SDRCFG_F_QOS_LO];
    wire [2:0] row_code   = geom_q[SDRCFG_F_ROW_HI:SDRCFG_F_ROW_LO];
    wire [2:0] col_code   = geom_q[SDRCFG_F_COL_HI:SDRCFG_F_COL_LO];
    wire [1:0] chip_code  = geom_q[SDRCFG_F_CHIPS_HI:SDRCFG_F_CHIPS_LO];
    wire [5:0] idle_powerdown_count = geom_q[SDRCFG_F_PDCNT_HI:SDRCFG_F_PDCNT_LO];
    wire       auto_pd_en = geom_q[SDRCFG_F_AUTOPD];
    wire       clkstop_en = geom_q[SDRCFG_F_CLKSTOP];
    wire       autoprecharge_line_sel = geom_q[SDRCFG_F_APSEL];

    // clamp codes to their legal range
    wire [2:0] burst_lim = (burst_code > SDRCFG_BURST_MAX) ? SDRCFG_BURST_MAX : burst_code;
    wire [2:0] qos_lim   = (qos_code > SDRCFG_QOS_MAX) ? SDRCFG_QOS_MAX : qos_code;
    wire [2:0] row_lim   = (row_code > SDRCFG_ROW_MAX) ? SDRCFG_ROW_MAX : row_code;
    wire [2:0] col_lim   = (col_code > SDRCFG_COL_MAX) ? SDRCFG_COL_MAX : col_code;
    wire [1:0] chip_lim  = (chip_code > FITTED_CHIPS) ? FITTED_CHIPS : chip_code;

    // derived values
    wire [4:0] burst_d   = 5'(5'h01 << burst_lim);
    wire [3:0] qos_d     = 4'(read_id >> qos_lim);
    wire [4:0] row_d     = SDRCFG_ROW_BASE + {2'h0, row_lim};
    wire [4:0] col_d     = SDRCFG_COL_BASE + {2'h0, col_lim};
    wire [3:0] ap_d      = autoprecharge_line_sel ? SDRCFG_AP_LINE_LO : SDRCFG_AP_LINE_HI;

    ////////////////////////////////////////////////////////////////////////
    // controller state machine

    // state command writes move the controller between states
    always_comb begin
        state_d = state_q;
        if (cmd_we) begin
            case (pwdata[2:0])
                SDRCFG_CMD_CONFIG: state_d = SDRCFG_ST_CONFIG;
                SDRCFG_CMD_ACTIVE: state_d = SDRCFG_ST_ACTIVE;
                SDRCFG_CMD_PAUSE:  state_d = SDRCFG_ST_PAUSED;
                SDRCFG_CMD_SLEEP:  state_d = SDRCFG_ST_LOWPWR;
                SDRCFG_CMD_WAKE:   state_d = SDRCFG_ST_ACTIVE;
                default:           state_d = state_q;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SDRCFG_ST_CONFIG;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    // geometry and refresh storage, writes only while open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            geom_q <= SDRCFG_GEOM_RESET;
            refr_q <= SDRCFG_REFRESH_RESET;
        end else begin
            if (geom_we) begin
                geom_q <= pwdata;
            end
            if (refr_we) begin
                refr_q <= pwdata[14:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_geom && cfg_open) begin
            rd_mux = geom_q;
        end else if (hit_refr && cfg_open) begin
            rd_mux = {17'h0, refr_q};
        end else if (hit_stat) begin
            rd_mux = {28'h0, FITTED_CHIPS, state_q};
        end
    end

    // one wait state, error on unmapped or locked access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= acc_phase;
            pslverr_q <= acc_phase && (unmapped || locked);
            prdata_q  <= (acc_phase && !pwrite) ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // direct mode register command

    logic        mr_pulse_q;
    logic [1:0]  mr_chip_q;
    logic [1:0]  mr_bank_q;
    logic [13:0] mr_addr_q;
    wire         mr_hit = dir_we &&
                          (pwdata[SDRCFG_F_DCMD_HI:SDRCFG_F_DCMD_LO] == SDRCFG_DCMD_MODEREG);

    // latch the mode register access and pulse once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr_pulse_q <= 1'b0;
            mr_chip_q  <= 2'h0;
            mr_bank_q  <= 2'h0;
            mr_addr_q  <= 14'h0;
        end else begin
            mr_pulse_q <= mr_hit;
            if (mr_hit) begin
                mr_chip_q <= pwdata[SDRCFG_F_DCHIP_HI:SDRCFG_F_DCHIP_LO];
                mr_bank_q <= pwdata[SDRCFG_F_DBANK_HI:SDRCFG_F_DBANK_LO];
                mr_addr_q <= pwdata[SDRCFG_F_DADDR_HI:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh and power-down timers

    wire active_run = (state_q == SDRCFG_ST_ACTIVE) || (state_q == SDRCFG_ST_PAUSED);
    wire refr_tick, pd_tick;

    sdrcfg_counter #(.W(15)) u_refresh (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (refr_we),
        .run     (active_run),
        .period  (refr_q),
        .expired (refr_tick),
        .count   ()
    );

    sdrcfg_counter #(.W(6)) u_idle (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (!fifo_empty),
        .run     (active_run && auto_pd_en),
        .period  (idle_powerdown_count),
        .expired (pd_tick),
        .count   ()
    );

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic       refresh_q;
    logic       cke_q;
    logic       clk_en_q;
    logic [3:0] chips_q;

    // cke, clock gate, refresh strobe and decoded fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_q <= 1'b0;
            cke_q     <= 1'b1;
            clk_en_q  <= 1'b1;
            chips_q   <= 4'h1;
        end else begin
            refresh_q <= refr_tick;
            if (!fifo_empty || !auto_pd_en) begin
                cke_q <= 1'b1;
            end else if (pd_tick) begin
                cke_q <= 1'b0;
            end
            clk_en_q  <= !clkstop_en || access_busy;
            chips_q   <= chip_mask(chip_lim);
        end
    end

    assign prdata                   = prdata_q;
    assign pready                   = pready_q;
    assign pslverr                  = pslverr_q;
    assign refresh_req              = refresh_q;
    assign cke                      = cke_q;
    assign mem_clk_en               = clk_en_q;
    assign selfref_allow            = geom_q[SDRCFG_F_SELFREF];
    assign forced_precharge_on      = geom_q[SDRCFG_F_FP_ON];
    assign forced_precharge_timeout = geom_q[SDRCFG_F_FPT_HI:SDRCFG_F_FPT_LO];
    assign chip_enables             = chips_q;
    assign modereg_pulse            = mr_pulse_q;
    assign modereg_chip             = mr_chip_q;
    assign modereg_bank             = mr_bank_q;
    assign modereg_addr             = mr_addr_q;

    // field decodes registered through geom_q-driven flops
    logic [4:0] burst_q;
    logic [3:0] qos_q;
    logic [4:0] row_q;
    logic [4:0] col_q;
    logic [3:0] ap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_q <= 5'(5'h01 << SDRCFG_GEOM_RESET[SDRCFG_F_BURST_HI:SDRCFG_F_BURST_LO]);
            qos_q   <= 4'h0;
            row_q   <= SDRCFG_ROW_BASE + 5'(SDRCFG_GEOM_RESET[SDRCFG_F_ROW_HI:SDRCFG_F_ROW_LO]);
            col_q   <= SDRCFG_COL_BASE;
            ap_q    <= SDRCFG_AP_LINE_HI;
        end else begin
            burst_q <= burst_d;
            qos_q   <= qos_d;
            row_q   <= row_d;
            col_q   <= col_d;
            ap_q    <= ap_d;
        end
    end
    assign burst_beats        = burst_q;
    assign qos_index          = qos_q;
    assign row_width          = row_q;
    assign col_width          = col_q;
    assign autoprecharge_line = ap_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_geom_locked;
        @(posedge pclk) disable iff (!presetn)
        (wr_phase && hit_geom && !cfg_open) |=> $stable(geom_q);
    endproperty
    a_geom_locked: assert property (p_geom_locked) else $error("geometry write leaked");
    property p_refr_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_phase && hit_refr && cfg_open) |=> (refr_q == $past(pwdata[14:0]));
    endproperty
    a_refr_write: assert property (p_refr_write) else $error("refresh write lost");
    property p_cke_wake;
        @(posedge pclk) disable iff (!presetn)
        (!fifo_empty) |=> cke;
    endproperty
    a_cke_wake: assert property (p_cke_wake) else $error("cke low with work queued");
    property p_cke_drop;
        @(posedge pclk) disable iff (!presetn)
        (pd_tick && fifo_empty && auto_pd_en) |=> !cke;
    endproperty
    a_cke_drop: assert property (p_cke_drop) else $error("cke did not drop");
    property p_clk_stop;
        @(posedge pclk) disable iff (!presetn)
        (clkstop_en && !access_busy) |=> !mem_clk_en;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("memory clock not stopped");
    property p_burst;
        @(posedge pclk) disable iff (!presetn)
        ##1 (burst_beats == (5'h01 << $past(burst_lim)));
    endproperty
    a_burst: assert property (p_burst) else $error("burst decode wrong");
    property p_row;
        @(posedge pclk) disable iff (!presetn)
        ##1 (row_width == 5'($past(row_lim) + 3'h3) + 5'h08);
    endproperty
    a_row: assert property (p_row) else $error("row width wrong");
    property p_chips;
        @(posedge pclk) disable iff (!presetn)
        chip_enables[0] && ((chip_enables[3:1] & ~chip_enables[2:0]) == 3'h0);
    endproperty
    a_chips: assert property (p_chips) else $error("chip mask not contiguous");
    property p_mr;
        @(posedge pclk) disable iff (!presetn)
        mr_hit |=> modereg_pulse ##1 !modereg_pulse || mr_hit;
    endproperty
    a_mr: assert property (p_mr) else $error("mode register pulse wrong");

endmodule : sdrcfg_top

//--- verif/sdrcfg_far_model.sv
// far-side model: command fifo occupancy, sdram access activity and read id
// assumes the bench requests each level just after a pclk edge
`timescale 1ns/1ps
module sdrcfg_far_model (
    input  wire logic       pclk,
    input  wire logic       idle_want,
    input  wire logic       busy_want,
    input  wire logic [7:0] id_want,
    output logic            fifo_empty,
    output logic            access_busy,
    output logic [7:0]      read_id
);
    // levels follow the request one cycle later, like a real queue
    always_ff @(posedge pclk) begin
        fifo_empty  <= idle_want;
        access_busy <= busy_want;
        read_id     <= id_want;
    end
endmodule : sdrcfg_far_model

//--- verif/sdrcfg_top_tb.sv
// self-checking bench for the sdram configuration and refresh block
// assumes the far model supplies fifo, access and read id levels
`timescale 1ns/1ps
module sdrcfg_top_tb;
    import sdrcfg_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, last_g;
    logic        pready, pslverr, er, idle_want = 1'b0, busy_want = 1'b1;
    logic        fifo_empty, access_busy, refresh_req, cke, mem_clk_en, selfref_allow;
    logic        forced_precharge_on, modereg_pulse;
    logic [6:0]  forced_precharge_timeout;
    logic [7:0]  read_id;
    logic [3:0]  qos_index, autoprecharge_line, chip_enables;
    logic [4:0]  burst_beats, row_width, col_width;
    logic [1:0]  modereg_chip, modereg_bank;
    logic [13:0] modereg_addr;
    int          err_total = 0, checked = 0, n;

    ////////////////////////////////////////////////////////////////////////////////
    // design and far side
    sdrcfg_top #(.FITTED_CHIPS(2'h3)) i_sdrcfg_top (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_empty, .access_busy,
        .read_id, .refresh_req, .cke, .mem_clk_en, .selfref_allow, .forced_precharge_on,
        .forced_precharge_timeout, .qos_index, .burst_beats, .row_width, .col_width,
        .autoprecharge_line, .chip_enables, .modereg_pulse, .modereg_chip, .modereg_bank,
        .modereg_addr);
    sdrcfg_far_model i_sdrcfg_far_model (.pclk, .idle_want, .busy_want, .id_want(8'hb6),
        .fifo_empty, .access_busy, .read_id);

    // 100 ns clock
    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    // compare one design value with its expectation
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(pready, 1'b1, 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for a level, edges counted in n
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== v && n < lim);
        if (s !== v) chk(1'b0, 1'b1);
    endtask : wait_for

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, SDRCFG_OFS_GEOMETRY, 32'h0);
        chk(rd, 32'h0001_0020);
        chk(er, 1'b0);
        apb(1'b0, SDRCFG_OFS_REFRESH, 32'h0);
        chk(rd, 32'h0000_0a60);
        chk(selfref_allow, 1'b0);
        $display("test reset done");
    endtask : t_reset

    // mode register access carrying burst code 2 in its low bits
    task automatic t_direct();
        apb(1'b1, SDRCFG_OFS_DIRECT, 32'h0029_0022);
        chk(modereg_pulse, 1'b1);
        chk({modereg_chip, modereg_bank, modereg_addr}, {2'h2, 2'h1, 14'h0022});
        chk(burst_beats, 5'h04);
        @(posedge pclk);
        chk(modereg_pulse, 1'b0);
        $display("test direct done");
    endtask : t_direct

    // every field code from zero up to its maximum, none above it
    task automatic t_geom();
        logic [2:0] c;
        for (int i = 0; i < 6; i++) begin
            c = (i > 4) ? 3'h4 : 3'(i);
            last_g = {i[0], 7'(i), 1'b1, i[1:0], c, c, 2'b00, 6'h00, i[0], 3'(i), c};
            apb(1'b1, SDRCFG_OFS_GEOMETRY, last_g);
            apb(1'b0, SDRCFG_OFS_GEOMETRY, 32'h0);
            chk(rd, last_g);
            chk(burst_beats, 5'h01 << c);
            chk(row_width, 5'h0b + 5'(i));
            chk(col_width, 5'h08 + 5'(c));
            chk(autoprecharge_line, i[0] ? 4'h8 : 4'ha);
            chk(chip_enables, 4'((5'h02 << i[1:0]) - 5'h01));
            chk(qos_index, 4'(8'hb6 >> c));
            chk({selfref_allow, forced_precharge_on, forced_precharge_timeout},
                {i[0], 1'b1, 7'(i)});
        end
        $display("test geometry done");
    endtask : t_geom

    task automatic t_states();
        apb(1'b1, SDRCFG_OFS_REFRESH, 32'h0000_0014);
        apb(1'b0, 12'h040, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, SDRCFG_OFS_STATE_CMD, 32'h7);
        apb(1'b0, SDRCFG_OFS_STATUS, 32'h0);
        chk(rd, 32'hd);
        apb(1'b1, SDRCFG_OFS_GEOMETRY, 32'hffff_ffff);
        chk(er, 1'b1);
        apb(1'b0, SDRCFG_OFS_REFRESH, 32'h0);
        chk(er, 1'b1);
        wait_for(refresh_req, 1'b1, 100);
        wait_for(refresh_req, 1'b1, 100);
        chk(n, 20);
        apb(1'b1, SDRCFG_OFS_STATE_CMD, 32'h3);
        apb(1'b0, SDRCFG_OFS_STATUS, 32'h0);
        chk(rd, 32'he);
        apb(1'b1, SDRCFG_OFS_STATE_CMD, 32'h2);
        apb(1'b0, SDRCFG_OFS_GEOMETRY, 32'h0);
        chk(rd, last_g);
        chk(er, 1'b0);
        apb(1'b1, SDRCFG_OFS_STATE_CMD, 32'h4);
        apb(1'b0, SDRCFG_OFS_STATUS, 32'h0);
        chk(rd, 32'hc);
        $display("test states done");
    endtask : t_states

    // idle count 4 with auto power-down and clock stop
    task automatic t_power();
        apb(1'b1, SDRCFG_OFS_GEOMETRY, 32'h0000_6200);
        apb(1'b1, SDRCFG_OFS_STATE_CMD, 32'h7);
        @(posedge pclk);
        idle_want <= 1'b1;
        wait_for(cke, 1'b0, 30);
        chk(n >= 5 && n <= 10, 1'b1);
        idle_want <= 1'b0;
        wait_for(cke, 1'b1, 30);
        chk(n <= 4, 1'b1);
        busy_want <= 1'b0;
        wait_for(mem_clk_en, 1'b0, 30);
        chk(n <= 4, 1'b1);
        busy_want <= 1'b1;
        wait_for(mem_clk_en, 1'b1, 30);
        chk(n <= 4, 1'b1);
        $display("test power done");
    endtask : t_power

    ////////////////////////////////////////////////////////////////////////////////
    // reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_direct();
        t_geom();
        t_states();
        t_power();
        final_report();
    end

    // watchdog well beyond the expected run
    initial begin
        #(100 * 5000);
        err_total++;
        final_report();
    end
endmodule : sdrcfg_top_tb
